// ===== rtl/chs_host_port.sv
// What this block does
// - Input overvoltage stops switching, code 01, alert.
// - System overvoltage halts the converter at once.
// - Boost overvoltage pauses boost, flags fault, alerts.
// - Battery overvoltage stops charging, flags fault, alerts.
// - Input source recloses switch; short or precharge current.
// - Overload latches battery switch off until exit event.
// - Answer at address 6AH, indices 0 to 14h.
// - Reads above index 14h return FFh.
// - Port works at 100 and 400 kbit/s.
// - START makes bus busy, STOP makes it free.
// - Bytes are eight bits, MSB first, then acknowledge.
// - Slave may hold clock low between bytes.
// - Receiver pulls data low on ninth clock.
// - Address is seven bits plus direction bit.
// - Undefined index gets not-acknowledge, then idle.
// - Multi-byte access everywhere except the fault register.
// - Fault register latches until read; thermistor always live.
// - Timeout flag high in default mode, low otherwise.
// - Power-on reset enters default mode with defaults.
// - Default mode charging has twelve-hour safety timer.
// - Any write enters host mode; kick or disable timer.
// - Watchdog expiry resets registers except kept fields.
// - Each unblocked event gives one 256 us alert pulse; events during a running pulse give none.
// - No new fault alert until read and cleared.
`timescale 1ns/1ps
`default_nettype none
module chs_host_port
  import chs_pkg::*;
#(
  parameter int P_ALERT_CYCLES = ALERT_CYCLES,
  parameter int P_MS_CYCLES = MS_CYCLES,
  parameter int P_SAFETY_MS = SAFETY_MS,
  parameter int P_WD_BASE_MS = WD_BASE_MS
) (
  input wire logic i_ref_clk,
  input wire logic i_srst,
  input wire logic i_link_clk,
  input wire logic i_scl,
  output logic o_scl,
  output logic o_scl_oe,
  input wire logic i_sda,
  output logic o_sda,
  output logic o_sda_oe,
  input wire logic i_input_overvoltage,
  input wire logic i_system_rail_overvoltage,
  input wire logic i_boost_output_overvoltage,
  input wire logic i_battery_overvoltage,
  input wire logic i_battery_discharged,
  input wire logic i_battery_below_short,
  input wire logic i_battery_below_low,
  input wire logic i_system_overcurrent,
  input wire logic i_input_present,
  input wire logic i_ship_exit_n,
  input wire logic [2:0] i_thermistor_fault_code,
  output logic o_switching_en,
  output logic o_charge_en,
  output logic o_boost_pause,
  output logic o_battery_switch_on,
  output logic [1:0] o_charge_current_sel,
  output logic [3:0] o_precharge_current_setting,
  output logic [7:0] o_input_source_control,
  output logic o_default_mode,
  output logic o_host_alert_n
);
  // ==========================================================================
  // Link domain: synchronisers.
  logic lrst_m, lrst;
  logic scl_m, scl_s, scl_d, sda_m, sda_s, sda_d;
  logic ack_m, ack_s;
  logic ack_tgl;
  logic [7:0] resp_data;
  always_ff @(posedge i_link_clk) begin
    lrst_m <= i_srst;
    lrst <= lrst_m;
    scl_m <= i_scl;
    scl_s <= scl_m;
    scl_d <= scl_s;
    sda_m <= i_sda;
    sda_s <= sda_m;
    sda_d <= sda_s;
    ack_m <= ack_tgl;
    ack_s <= ack_m;
  end
  logic scl_rise, scl_fall, start_det, stop_det;
  assign scl_rise = scl_s & ~scl_d;
  assign scl_fall = ~scl_s & scl_d;
  assign start_det = scl_s & scl_d & sda_d & ~sda_s;
  assign stop_det = scl_s & scl_d & ~sda_d & sda_s;
  // ==========================================================================
  // Link domain: byte engine.
  chs_link_e lst, next_lst;
  chs_kind_e kind, next_kind;
  logic [7:0] shift, next_shift, ptr, next_ptr, req_idx, next_req_idx;
  logic [7:0] req_wdata, next_req_wdata, fetch_idx;
  logic [3:0] bcnt, next_bcnt;
  logic nack, next_nack, rd, next_rd, lock, next_lock, ret_send, next_ret_send;
  logic req_tgl, next_req_tgl, req_we, next_req_we, sda_oe, next_sda_oe;
  logic do_req, do_we, done;
  assign done = (ack_s == req_tgl);
  always_comb begin
    next_lst = lst;
    next_kind = kind;
    next_shift = shift;
    next_ptr = ptr;
    next_bcnt = bcnt;
    next_nack = nack;
    next_rd = rd;
    next_lock = lock;
    next_ret_send = ret_send;
    next_sda_oe = sda_oe;
    do_req = 1'b0;
    do_we = 1'b0;
    fetch_idx = lock ? UNMAPPED_DATA : ptr;
    case (lst)
      L_IDLE: begin
      end
      L_RECV: begin
        if (scl_rise) begin
          next_shift = {shift[6:0], sda_s};
          next_bcnt = bcnt + 4'h1;
        end else if (scl_fall && bcnt == 4'h8) begin
          next_bcnt = 4'h0;
          next_lst = L_ACK;
          next_nack = 1'b1;
          case (kind)
            K_ADDR: begin
              if (shift[7:1] == SLAVE_ADDR) begin
                next_rd = shift[0];
                next_nack = 1'b0;
                next_sda_oe = 1'b1;
                next_lock = 1'b0;
              end else begin
                next_lst = L_IDLE;
              end
            end
            K_INDEX: begin
              if (shift <= LAST_INDEX) begin
                next_ptr = shift;
                next_nack = 1'b0;
                next_sda_oe = 1'b1;
              end
            end
            default: begin
              if (!lock && ptr <= LAST_INDEX) begin
                do_req = 1'b1;
                do_we = 1'b1;
                fetch_idx = ptr;
                next_ret_send = 1'b0;
                next_lst = L_WAIT;
              end
            end
          endcase
        end
      end
      L_ACK: begin
        if (scl_fall) begin
          next_sda_oe = 1'b0;
          if (nack) begin
            next_lst = L_IDLE;
          end else if (rd) begin
            do_req = 1'b1;
            next_ret_send = 1'b1;
            next_lst = L_WAIT;
          end else begin
            next_lst = L_RECV;
            next_kind = (kind == K_ADDR) ? K_INDEX : K_DATA;
            if (kind == K_DATA) begin
              next_ptr = ptr + 8'h01;
            end
          end
        end
      end
      L_WAIT: begin
        if (done) begin
          if (ret_send) begin
            next_shift = resp_data;
            next_sda_oe = ~resp_data[7];
            next_bcnt = 4'h0;
            next_lst = L_SEND;
          end else begin
            next_nack = 1'b0;
            next_sda_oe = 1'b1;
            next_lst = L_ACK;
          end
        end
      end
      L_SEND: begin
        if (scl_fall) begin
          next_shift = {shift[6:0], 1'b0};
          next_bcnt = bcnt + 4'h1;
          next_sda_oe = ~shift[6];
          if (bcnt == 4'h7) begin
            next_sda_oe = 1'b0;
            next_lst = L_MACK;
          end
        end
      end
      L_MACK: begin
        if (scl_rise) begin
          next_nack = sda_s;
        end else if (scl_fall) begin
          if (nack) begin
            next_lst = L_IDLE;
          end else begin
            next_ptr = ptr + 8'h01;
            fetch_idx = lock ? UNMAPPED_DATA : ptr + 8'h01;
            do_req = 1'b1;
            next_ret_send = 1'b1;
            next_lst = L_WAIT;
          end
        end
      end
      default: begin
        next_lst = L_IDLE;
      end
    endcase
    if (stop_det) begin
      next_lst = L_IDLE;
      next_sda_oe = 1'b0;
    end
    if (start_det) begin
      next_lst = L_RECV;
      next_kind = K_ADDR;
      next_bcnt = 4'h0;
      next_sda_oe = 1'b0;
    end
    next_req_tgl = req_tgl ^ do_req;
    next_req_we = do_req ? do_we : req_we;
    next_req_idx = do_req ? fetch_idx : req_idx;
    next_req_wdata = do_req ? shift : req_wdata;
    if (do_req && fetch_idx == FAULT_INDEX) begin
      next_lock = 1'b1;
    end
  end
  always_ff @(posedge i_link_clk) begin
    if (lrst) begin
      lst <= L_IDLE;
      kind <= K_ADDR;
      shift <= 8'h00;
      ptr <= 8'h00;
      bcnt <= 4'h0;
      nack <= 1'b0;
      rd <= 1'b0;
      lock <= 1'b0;
      ret_send <= 1'b0;
      sda_oe <= 1'b0;
      req_tgl <= 1'b0;
      req_we <= 1'b0;
      req_idx <= 8'h00;
      req_wdata <= 8'h00;
    end else begin
      lst <= next_lst;
      kind <= next_kind;
      shift <= next_shift;
      ptr <= next_ptr;
      bcnt <= next_bcnt;
      nack <= next_nack;
      rd <= next_rd;
      lock <= next_lock;
      ret_send <= next_ret_send;
      sda_oe <= next_sda_oe;
      req_tgl <= next_req_tgl;
      req_we <= next_req_we;
      req_idx <= next_req_idx;
      req_wdata <= next_req_wdata;
    end
  end
  // The link clock oversamples both lines well beyond fast-mode rates.
  assign o_scl = 1'b0;
  assign o_sda = 1'b0;
  assign o_scl_oe = (lst == L_WAIT);
  assign o_sda_oe = sda_oe;
  // ==========================================================================
  // Core domain: synchronisers.
  logic rq_m, rq_s, rq_d;
  logic [12:0] sense_m, sense_s;
  always_ff @(posedge i_ref_clk) begin
    rq_m <= req_tgl;
    rq_s <= rq_m;
    rq_d <= rq_s;
    sense_m <= {i_input_overvoltage, i_system_rail_overvoltage, i_boost_output_overvoltage,
                i_battery_overvoltage, i_battery_discharged, i_battery_below_short,
                i_battery_below_low, i_system_overcurrent, i_input_present, i_ship_exit_n,
                i_thermistor_fault_code};
    sense_s <= sense_m;
  end
  logic ov_in, ov_sys, ov_boost, ov_bat, bat_dis, bat_short, bat_low, ocur, in_pres, exit_n;
  logic [2:0] therm;
  assign {ov_in, ov_sys, ov_boost, ov_bat, bat_dis, bat_short, bat_low, ocur, in_pres,
          exit_n, therm} = sense_s;
  // ==========================================================================
  // Core domain: registers, watchdog, faults and alert.
  logic [REG_COUNT-1:0][7:0] regs, next_regs;
  logic [7:0] flt_latch, next_latch, live, live_q, view, wval, next_resp;
  logic [CNT_W-1:0] ms_cnt, next_ms_cnt, wd_ms, next_wd_ms, wd_limit;
  logic [CNT_W-1:0] safety_ms, next_safety_ms, alert_cnt, next_alert_cnt;
  logic default_mode, next_default, safety_exp, next_safety_exp, next_ack;
  logic fault_block, next_block, read_seen, next_seen, batsw_latch, next_batsw;
  logic dis_off, next_dis_off, pres_q, ship_q, exit_q, shipdis, exit_evt;
  logic req_edge, wr_hit, fault_rd, kick, ms_tick, wd_expire, fault_evt, fire;
  logic [1:0] wd_period;
  assign req_edge = rq_s ^ rq_d;
  assign wr_hit = req_edge & req_we;
  assign fault_rd = req_edge & ~req_we & (req_idx == FAULT_INDEX);
  assign kick = wr_hit & (req_idx == KICK_INDEX) & req_wdata[KICK_BIT];
  assign ms_tick = (ms_cnt == CNT_W'(P_MS_CYCLES - 1));
  assign wd_period = regs[WD_INDEX[4:0]][WD_LSB+:2];
  assign shipdis = regs[SHIP_INDEX[4:0]][SHIP_DIS_BIT];
  assign exit_evt = (in_pres & ~pres_q) | (ship_q & ~shipdis) | (exit_q & ~exit_n);
  assign wd_expire = ~default_mode & (wd_period != 2'h0) & (wd_ms >= wd_limit);
  always_comb begin
    case (wd_period)
      2'h1: wd_limit = CNT_W'(P_WD_BASE_MS);
      2'h2: wd_limit = CNT_W'(2 * P_WD_BASE_MS);
      default: wd_limit = CNT_W'(4 * P_WD_BASE_MS);
    endcase
    live = {default_mode, ov_boost, CHG_CODE_NONE, ov_bat, therm};
    if (ov_in) begin
      live[FLT_CHG_LSB+:2] = CHG_CODE_INPUT_OV;
    end else if (safety_exp) begin
      live[FLT_CHG_LSB+:2] = CHG_CODE_TIMER;
    end
    view = {default_mode, flt_latch[6:3] | live[6:3], therm};
    fault_evt = |(live & ~live_q);
    fire = (fault_evt & ~fault_block) | (in_pres & ~pres_q);
  end
  always_comb begin
    next_regs = regs;
    next_default = default_mode;
    next_ms_cnt = ms_tick ? '0 : ms_cnt + 1'b1;
    next_wd_ms = wd_ms;
    next_safety_ms = safety_ms;
    next_safety_exp = safety_exp;
    next_latch = (fault_rd ? 8'h00 : flt_latch) | live;
    next_resp = resp_data;
    next_ack = ack_tgl;
    wval = req_wdata;
    if (req_idx == KICK_INDEX) begin
      wval[KICK_BIT] = 1'b0;
    end
    if (default_mode || wd_period == 2'h0 || kick || wd_expire) begin
      next_wd_ms = '0;
    end else if (ms_tick) begin
      next_wd_ms = wd_ms + 1'b1;
    end
    if (wd_expire) begin
      next_default = 1'b1;
      for (int i = 0; i < REG_COUNT; i++) begin
        next_regs[i] = (regs[i] & WD_KEEP[i]) | (REG_RESET[i] & ~WD_KEEP[i]);
      end
    end
    if (wr_hit) begin
      next_default = 1'b0;
      if (req_idx <= LAST_INDEX && req_idx != FAULT_INDEX) begin
        next_regs[req_idx[4:0]] = wval;
      end
    end
    if (!default_mode) begin
      next_safety_ms = '0;
      next_safety_exp = 1'b0;
    end else if (ms_tick && !safety_exp && !ov_bat && !ov_in) begin
      next_safety_ms = safety_ms + 1'b1;
      next_safety_exp = (safety_ms == CNT_W'(P_SAFETY_MS - 1));
    end
    if (req_edge) begin
      next_ack = ~ack_tgl;
      if (!req_we) begin
        if (req_idx > LAST_INDEX) begin
          next_resp = UNMAPPED_DATA;
        end else if (req_idx == FAULT_INDEX) begin
          next_resp = view;
        end else begin
          next_resp = regs[req_idx[4:0]];
        end
      end
    end
    next_block = fault_block;
    next_seen = read_seen | fault_rd;
    if (fault_evt && !fault_block) begin
      next_block = 1'b1;
      next_seen = 1'b0;
    end else if (read_seen && live[6:0] == 7'h00) begin
      next_block = 1'b0;
    end
    next_alert_cnt = alert_cnt;
    if (fire && alert_cnt == '0) begin
      next_alert_cnt = CNT_W'(P_ALERT_CYCLES);
    end else if (alert_cnt != '0) begin
      next_alert_cnt = alert_cnt - 1'b1;
    end
    next_batsw = ocur | (batsw_latch & ~exit_evt);
    next_dis_off = ~in_pres & (dis_off | bat_dis);
  end
  always_ff @(posedge i_ref_clk) begin
    if (i_srst) begin
      regs <= REG_RESET;
      default_mode <= 1'b1;
      ms_cnt <= '0;
      wd_ms <= '0;
      safety_ms <= '0;
      safety_exp <= 1'b0;
      flt_latch <= 8'h00;
      live_q <= LIVE_RESET;
      resp_data <= 8'h00;
      ack_tgl <= 1'b0;
      fault_block <= 1'b0;
      read_seen <= 1'b0;
      alert_cnt <= '0;
      batsw_latch <= 1'b0;
      dis_off <= 1'b0;
      pres_q <= 1'b0;
      ship_q <= 1'b0;
      exit_q <= 1'b1;
      o_switching_en <= 1'b0;
      o_charge_en <= 1'b0;
      o_boost_pause <= 1'b0;
      o_battery_switch_on <= 1'b0;
      o_charge_current_sel <= CUR_FAST;
      o_precharge_current_setting <= 4'h0;
      o_input_source_control <= REG_RESET[0];
      o_default_mode <= 1'b1;
      o_host_alert_n <= 1'b1;
    end else begin
      regs <= next_regs;
      default_mode <= next_default;
      ms_cnt <= next_ms_cnt;
      wd_ms <= next_wd_ms;
      safety_ms <= next_safety_ms;
      safety_exp <= next_safety_exp;
      flt_latch <= next_latch;
      live_q <= live;
      resp_data <= next_resp;
      ack_tgl <= next_ack;
      fault_block <= next_block;
      read_seen <= next_seen;
      alert_cnt <= next_alert_cnt;
      batsw_latch <= next_batsw;
      dis_off <= next_dis_off;
      pres_q <= in_pres;
      ship_q <= shipdis;
      exit_q <= exit_n;
      o_switching_en <= ~(ov_in | ov_sys | ov_boost | regs[0][HIZ_BIT]);
      o_charge_en <= ~(ov_bat | ov_in | safety_exp);
      o_boost_pause <= ov_boost;
      o_battery_switch_on <= ~(next_batsw | next_dis_off | shipdis);
      o_charge_current_sel <= bat_short ? CUR_SHORT : (bat_low ? CUR_PRE : CUR_FAST);
      o_precharge_current_setting <= regs[PRE_INDEX[4:0]][PRE_LSB+:4];
      o_input_source_control <= regs[0];
      o_default_mode <= default_mode;
      o_host_alert_n <= (next_alert_cnt == '0);
    end
  end
  // ==========================================================================
  // Assertions.
  property p_input_ov;
    @(posedge i_ref_clk) disable iff (i_srst) ov_in |=> !o_switching_en && !o_charge_en;
  endproperty
  a_input_ov: assert property (p_input_ov) else $error("switching not stopped");
  property p_bat_ov;
    @(posedge i_ref_clk) disable iff (i_srst) ov_bat |=> !o_charge_en && flt_latch[FLT_BAT];
  endproperty
  a_bat_ov: assert property (p_bat_ov) else $error("charge not stopped");
  property p_boost_ov;
    @(posedge i_ref_clk) disable iff (i_srst) $rose(ov_boost) |=> o_boost_pause && !o_switching_en;
  endproperty
  a_boost_ov: assert property (p_boost_ov) else $error("boost not paused");
  property p_unmapped;
    @(posedge i_ref_clk) disable iff (i_srst)
      req_edge && !req_we && req_idx > LAST_INDEX |=> resp_data == UNMAPPED_DATA;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read wrong");
  property p_alert_len;
    @(posedge i_ref_clk) disable iff (i_srst)
      $fell(o_host_alert_n) |-> alert_cnt == CNT_W'(P_ALERT_CYCLES);
  endproperty
  a_alert_len: assert property (p_alert_len) else $error("alert length wrong");
  property p_alert_block;
    @(posedge i_ref_clk) disable iff (i_srst)
      fault_block && alert_cnt == '0 && !(in_pres && !pres_q) |=> o_host_alert_n;
  endproperty
  a_alert_block: assert property (p_alert_block) else $error("blocked alert");
  property p_wd_flag;
    @(posedge i_ref_clk) disable iff (i_srst) view[FLT_WD] == default_mode;
  endproperty
  a_wd_flag: assert property (p_wd_flag) else $error("timeout flag wrong");
  property p_wd_expire;
    @(posedge i_ref_clk) disable iff (i_srst)
      wd_expire && !wr_hit |=> default_mode && regs[2] == REG_RESET[2];
  endproperty
  a_wd_expire: assert property (p_wd_expire) else $error("expiry reset missed");
  property p_overload;
    @(posedge i_ref_clk) disable iff (i_srst) ocur |=> !o_battery_switch_on;
  endproperty
  a_overload: assert property (p_overload) else $error("switch not latched");
  property p_bad_index;
    @(posedge i_link_clk) disable iff (lrst)
      lst == L_RECV && kind == K_INDEX && scl_fall && bcnt == 4'h8 && shift > LAST_INDEX
      |=> lst == L_ACK && !o_sda_oe && nack;
  endproperty
  a_bad_index: assert property (p_bad_index) else $error("bad index acked");
endmodule : chs_host_port
`default_nettype wire

// ===== rtl/chs_pkg.sv
package chs_pkg;
  // ==========================================================================
  // Register map.
  localparam logic [6:0] SLAVE_ADDR = 7'h6A;
  localparam logic [7:0] LAST_INDEX = 8'h14;
  localparam logic [7:0] FAULT_INDEX = 8'h0C;
  localparam logic [7:0] UNMAPPED_DATA = 8'hFF;
  localparam logic [7:0] KICK_INDEX = 8'h03;
  localparam int KICK_BIT = 6;
  localparam logic [7:0] PRE_INDEX = 8'h04;
  localparam int PRE_LSB = 4;
  localparam logic [7:0] WD_INDEX = 8'h07;
  localparam int WD_LSB = 4;
  localparam logic [7:0] SHIP_INDEX = 8'h09;
  localparam int SHIP_DIS_BIT = 5;
  localparam int HIZ_BIT = 7;
  localparam int REG_COUNT = 21;
  localparam logic [REG_COUNT-1:0][7:0] REG_RESET =
    '{0: 8'h48, 1: 8'h06, 2: 8'h11, default: 8'h00};
  localparam logic [REG_COUNT-1:0][7:0] WD_KEEP =
    '{0: 8'h3F, 1: 8'h1F, 9: 8'h2C, 13: 8'h7F, default: 8'h00};
  // ==========================================================================
  // Fault register layout.
  localparam int FLT_WD = 7;
  localparam int FLT_BOOST = 6;
  localparam int FLT_CHG_LSB = 4;
  localparam int FLT_BAT = 3;
  localparam logic [1:0] CHG_CODE_NONE = 2'h0;
  localparam logic [1:0] CHG_CODE_INPUT_OV = 2'h1;
  localparam logic [1:0] CHG_CODE_TIMER = 2'h3;
  localparam logic [7:0] LIVE_RESET = 8'h80;
  localparam logic [1:0] CUR_FAST = 2'h0;
  localparam logic [1:0] CUR_SHORT = 2'h1;
  localparam logic [1:0] CUR_PRE = 2'h2;
  // ==========================================================================
  // Timing.
  localparam int CLK_PERIOD_NS = 5;
  localparam int ALERT_PULSE_NS = 256000;
  localparam int ALERT_CYCLES = ALERT_PULSE_NS / CLK_PERIOD_NS;
  localparam int MS_NS = 1000000;
  localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
  localparam int SAFETY_HOURS = 12;
  localparam int SAFETY_MS = SAFETY_HOURS * 3600 * 1000;
  localparam int WD_BASE_S = 40;
  localparam int WD_BASE_MS = WD_BASE_S * 1000;
  localparam int CNT_W = 26;
  // ==========================================================================
  // Link states and byte kinds.
  typedef enum logic [5:0] {
    L_IDLE = 6'h01, L_RECV = 6'h02, L_ACK = 6'h04,
    L_WAIT = 6'h08, L_SEND = 6'h10, L_MACK = 6'h20
  } chs_link_e;
  typedef enum logic [2:0] {K_ADDR = 3'h1, K_INDEX = 3'h2, K_DATA = 3'h4} chs_kind_e;
endpackage : chs_pkg

// ===== verif/chs_i2c_master.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Bus master model clocked by the link clock.
module chs_i2c_master (
  input wire logic i_clk,
  input wire logic i_scl,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda
);
  logic [8:0] res;
  event done;
  initial begin
    o_scl = 1'h1;
    o_sda = 1'h1;
  end
  // Half a bit of 16 link cycles keeps the rate below 400 kbit/s.
  task automatic half();
    repeat (16) @(posedge i_clk);
  endtask : half
  task automatic bit_io(input logic b, output logic r);
    int n;
    o_sda <= b;
    half();
    o_scl <= 1'h1;
    n = 0;
    // Waits while the slave holds the clock low.
    while (i_scl !== 1'h1 && n < 400) begin
      @(posedge i_clk);
      n++;
    end
    half();
    r = i_sda;
    o_scl <= 1'h0;
  endtask : bit_io
  // Start and repeated start.
  task automatic start();
    o_sda <= 1'h1;
    half();
    o_scl <= 1'h1;
    half();
    o_sda <= 1'h0;
    half();
    o_scl <= 1'h0;
  endtask : start
  task automatic stop();
    o_sda <= 1'h0;
    half();
    o_scl <= 1'h1;
    half();
    o_sda <= 1'h1;
    half();
  endtask : stop
  // Eight bits MSB first, then the acknowledge bit.
  task automatic xfer(input logic [7:0] d, input logic mack, input logic rd);
    logic [7:0] q;
    logic a;
    for (int i = 7; i >= 0; i--) begin
      bit_io(rd | d[i], q[i]);
    end
    bit_io(rd ? mack : 1'h1, a);
    res = {rd ? mack : a, q};
    -> done;
  endtask : xfer
endmodule : chs_i2c_master
`default_nettype wire

// ===== verif/test_chs_host_port.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================================
// Self-checking bench of the host port.
module test_chs_host_port
  import chs_pkg::*;
;
  localparam int A = 16;
  logic clk = 1'h0, lclk = 1'h0, srst = 1'h1, m_scl, m_sda, scl_oe, sda_oe;
  logic sw, dflt, alert, chg, bp, bsw;
  logic [1:0] sel;
  logic [8:0] sn = 9'h000;
  logic [2:0] th = 3'h0;
  logic [7:0] src, v;
  logic [8:0] q[$];
  int seed = 11288, checks = 0, mismatches = 0, n;
  wire scl_w = m_scl & ~scl_oe;
  wire sda_w = m_sda & ~sda_oe;
  initial forever #2.5 clk = ~clk;
  initial begin
    #7;
    forever #40 lclk = ~lclk;
  end
  chs_i2c_master m (.i_clk(lclk), .i_scl(scl_w), .i_sda(sda_w), .o_scl(m_scl), .o_sda(m_sda));
  chs_host_port #(.P_ALERT_CYCLES(A), .P_MS_CYCLES(20), .P_SAFETY_MS(100000),
    .P_WD_BASE_MS(10)) uut (
    .i_ref_clk(clk), .i_srst(srst), .i_link_clk(lclk), .i_scl(scl_w), .o_scl(),
    .o_scl_oe(scl_oe), .i_sda(sda_w), .o_sda(), .o_sda_oe(sda_oe),
    .i_input_overvoltage(sn[0]), .i_system_rail_overvoltage(sn[1]),
    .i_boost_output_overvoltage(sn[2]), .i_battery_overvoltage(sn[3]),
    .i_battery_discharged(sn[4]), .i_battery_below_short(sn[5]),
    .i_battery_below_low(sn[6]), .i_system_overcurrent(sn[7]), .i_input_present(sn[8]),
    .i_ship_exit_n(1'h1), .i_thermistor_fault_code(th), .o_switching_en(sw),
    .o_charge_en(chg), .o_boost_pause(bp), .o_battery_switch_on(bsw), .o_charge_current_sel(sel),
    .o_precharge_current_setting(), .o_input_source_control(src),
    .o_default_mode(dflt), .o_host_alert_n(alert));
  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic put(input logic [7:0] d, input logic rd, input logic [8:0] e);
    q.push_back(e);
    m.xfer(d, e[8], rd);
  endtask : put
  task automatic hdr(input logic [7:0] idx, input logic ok);
    m.start();
    put({SLAVE_ADDR, 1'h0}, 1'h0, {1'h0, SLAVE_ADDR, 1'h0});
    put(idx, 1'h0, {~ok, idx});
  endtask : hdr
  task automatic rd(input logic [7:0] idx, input int k, input logic [7:0] e [3]);
    hdr(idx, 1'h1);
    m.start();
    put({SLAVE_ADDR, 1'h1}, 1'h0, {1'h0, SLAVE_ADDR, 1'h1});
    for (int i = 0; i < k; i++) put(8'hFF, 1'h1, {i == k - 1, e[i]});
    m.stop();
  endtask : rd
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  initial forever begin
    @(m.done);
    chk(m.res, q.pop_front());
  end
  initial begin
    #900000;
    mismatches++;
    print_verdict();
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'h0;
    repeat (8) @(posedge lclk);
    chk({dflt, src}, {1'h1, 8'h48});
    rd(8'h00, 3, '{8'h48, 8'h06, 8'h11});
    v = 8'($random(seed)) & 8'h7F;
    hdr(8'h00, 1'h1);
    put(v, 1'h0, {1'h0, v});
    put(8'h05, 1'h0, 9'h005);
    m.stop();
    @(negedge clk);
    chk({dflt, src}, {1'h0, v});
    rd(8'h14, 2, '{8'h00, 8'hFF, 8'h00});
    hdr(8'h15, 1'h0);
    m.stop();
    m.start();
    put({7'h6B, 1'h0}, 1'h0, {1'h1, 7'h6B, 1'h0});
    m.stop();
    chk({8'h00, sw}, 9'h001);
    @(posedge clk);
    th <= 3'($random(seed));
    sn[0] <= 1'h1;
    n = 0;
    while (alert !== 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    n = 0;
    while (alert === 1'h0 && n < 100) begin
      @(negedge clk);
      n++;
    end
    chk(9'(n), 9'(A));
    chk({8'h00, sw}, 9'h000);
    chk({8'h00, chg}, 9'h000);
    @(posedge clk);
    sn[0] <= 1'h0;
    rd(FAULT_INDEX, 1, '{{4'h1, 1'h0, th}, 8'h00, 8'h00});
    rd(FAULT_INDEX, 1, '{{5'h00, th}, 8'h00, 8'h00});
    @(posedge clk);
    sn <= 9'h08C;
    repeat (6) @(negedge clk);
    chk({6'h00, bp, chg, bsw}, 9'h004);
    @(posedge clk);
    sn <= 9'h020;
    repeat (6) @(negedge clk);
    chk({6'h00, bsw, sel}, 9'h001);
    @(posedge clk);
    sn <= 9'h120;
    repeat (6) @(negedge clk);
    chk({6'h00, bsw, sel}, 9'h005);
    print_verdict();
  end
endmodule : test_chs_host_port
`default_nettype wire
